// file: src/nirq_status.v
// event flag collector with clear-on-read status registers, mask registers
// and one interrupt request line, reached over an AHB-Lite slave port.
// assumes event inputs synchronous to ref_clk, pulses one cycle wide,
// and a single master with only whole-word single transfers.
//
// How it works
// - oscillator stable after enable sets bit 7
// - receiving, fifo above 300 bytes sets level flag
// - transmitting, fifo below 200 bytes sets level flag
// - rx start, rx end, tx end, collision flags
// - disturbance restart sets bit 1; bit 0 unused
// - main event register clears when read
// - command done, no-response, general timer flags
// - field rise bit 4, field drop bit 3
// - collision avoidance collision sets bit 2
// - guard time after own field sets bit 1
// - target mode bit rate recognised sets bit 0
// - timer and field register clears when read
// - soft framing bit 5, crc 7, parity 6
// - hard framing error sets bit 4
// - wake-up timeout flag only with every-timeout option
// - amplitude change above reference sets bit 2
// - phase change above reference sets bit 1
// - capacitance change above reference sets bit 0
// - mask bit one blocks the interrupt request
// - error mask bits mirror error register layout
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "nirq_defs.vh"

module nirq_status #(
   parameter FIFO_CNT_W = 10,
   parameter MEAS_W     = 8,
   parameter WL_RX      = `NIRQ_WL_RX_BYTES,
   parameter WL_TX      = `NIRQ_WL_TX_BYTES
) (
   // clock and reset
   input  wire                  ref_clk,
   input  wire                  reset,
   // ahb-lite slave
   input  wire                  hsel,
   input  wire [31:0]           haddr,
   input  wire [1:0]            htrans,
   input  wire                  hwrite,
   input  wire [2:0]            hsize,
   input  wire [31:0]           hwdata,
   input  wire                  hready,
   output wire                  hreadyout,
   output wire                  hresp,
   output wire [31:0]           hrdata,
   // oscillator
   output wire                  osc_en,
   input  wire                  osc_stable,
   // fifo and framing
   input  wire                  rx_active,
   input  wire                  tx_active,
   input  wire [FIFO_CNT_W-1:0] fifo_count,
   input  wire                  rx_start,
   input  wire                  rx_end,
   input  wire                  tx_end,
   input  wire                  bit_collision,
   input  wire                  electromagnetic_disturbance,
   // timers and field
   input  wire                  dcmd_done,
   input  wire                  nrt_expire,
   input  wire                  gpt_expire,
   input  wire                  ext_field_on,
   input  wire                  ca_collision,
   input  wire                  ca_guard_done,
   input  wire                  target_mode,
   input  wire                  bitrate_found,
   // errors
   input  wire                  crc_err,
   input  wire                  parity_err,
   input  wire                  soft_framing_err,
   input  wire                  hard_framing_err,
   // wake-up
   input  wire                  wakeup_timeout,
   input  wire                  am_done,
   input  wire [MEAS_W-1:0]     am_delta,
   input  wire                  pm_done,
   input  wire [MEAS_W-1:0]     pm_delta,
   input  wire                  cm_done,
   input  wire [MEAS_W-1:0]     cm_delta,
   // interrupt request
   output wire                  irq
);

   // flags update: a set in the clearing cycle wins
   function [7:0] flag_upd;
      input [7:0] cur;
      input [7:0] set;
      input       clr;
      begin
         flag_upd = (clr ? 8'h00 : cur) | set;
      end
   endfunction

   // byte address of a register index
   function [7:0] idx_addr;
      input [7:0] idx;
      begin
         idx_addr = {idx[5:0], 2'b00};
      end
   endfunction

   // zero-extended read word of an 8-bit register
   function [31:0] word8;
      input [7:0] v;
      begin
         word8 = {24'h000000, v};
      end
   endfunction

   // rising edge of a level against its last sample
   function rise;
      input cur;
      input prev;
      begin
         rise = cur & ~prev;
      end
   endfunction

   // wake-up measurement strictly beyond its stored reference
   function over_ref;
      input              done;
      input [MEAS_W-1:0] delta;
      input [MEAS_W-1:0] ref_v;
      begin
         over_ref = done & (delta > ref_v);
      end
   endfunction

   // registers
   reg  [7:0]  main_event_flags_r;
   reg  [7:0]  timer_field_event_flags_r;
   reg  [7:0]  error_wakeup_event_flags_r;
   reg  [7:0]  mask_main_r;
   reg  [7:0]  mask_tf_r;
   reg  [7:0]  mask_err_r;
   reg  [1:0]  ctrl_r;
   reg  [23:0] wref_r;
   reg  [31:0] hrdata_r;
   reg         hreadyout_r;
   reg         hresp_r;
   reg         irq_r;
   reg         wr_pend_r;
   reg  [7:0]  wr_addr_r;
   reg         osc_stable_d_r;
   reg         field_d_r;
   reg         wl_cond_d_r;

   // next values
   reg  [7:0]  mask_main_nxt;
   reg  [7:0]  mask_tf_nxt;
   reg  [7:0]  mask_err_nxt;
   reg  [1:0]  ctrl_nxt;
   reg  [23:0] wref_nxt;
   reg  [31:0] rd_nxt;
   reg         clr_main;
   reg         clr_tf;
   reg         clr_err;

   wire        acc;
   wire        rd_acc;
   wire [7:0]  a_addr;
   wire        wl_cond;
   wire [7:0]  set_main;
   wire [7:0]  set_tf;
   wire [7:0]  set_err;
   wire [7:0]  main_nxt;
   wire [7:0]  tf_nxt;
   wire [7:0]  err_nxt;
   wire        irq_nxt;
   wire        osc_rise;
   wire        wl_rise;
   wire        field_rise;
   wire        field_fall;

   assign hreadyout = hreadyout_r;
   assign hresp     = hresp_r;
   assign hrdata    = hrdata_r;
   assign irq       = irq_r;
   assign osc_en    = ctrl_r[`NIRQ_CTRL_OSC_EN];

   // address phase accepted
   assign acc    = hsel & htrans[1] & hready;
   assign rd_acc = acc & ~hwrite;
   assign a_addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;

   // fifo water level condition, flagged on its rising edge
   assign wl_cond = (rx_active & (fifo_count > WL_RX[FIFO_CNT_W-1:0])) |
                    (tx_active & (fifo_count < WL_TX[FIFO_CNT_W-1:0]));

   // level edges against last cycle's sample
   assign osc_rise   = rise(osc_stable, osc_stable_d_r);
   assign wl_rise    = rise(wl_cond, wl_cond_d_r);
   assign field_rise = rise(ext_field_on, field_d_r);
   assign field_fall = rise(field_d_r, ext_field_on);

   assign set_main[`NIRQ_MAIN_OSC]  = osc_en & osc_rise;
   assign set_main[`NIRQ_MAIN_WL]   = wl_rise;
   assign set_main[`NIRQ_MAIN_RXS]  = rx_start;
   assign set_main[`NIRQ_MAIN_RXE]  = rx_end;
   assign set_main[`NIRQ_MAIN_TXE]  = tx_end;
   assign set_main[`NIRQ_MAIN_COL]  = bit_collision;
   assign set_main[`NIRQ_MAIN_REST] = electromagnetic_disturbance;
   assign set_main[0]               = 1'b0;

   // timer and field set terms
   assign set_tf[`NIRQ_TF_CMD]      = dcmd_done;
   assign set_tf[`NIRQ_TF_NRT]      = nrt_expire;
   assign set_tf[`NIRQ_TF_GPT]      = gpt_expire;
   assign set_tf[`NIRQ_TF_FON]      = field_rise;
   assign set_tf[`NIRQ_TF_FOFF]     = field_fall;
   assign set_tf[`NIRQ_TF_CA_COL]   = ca_collision;
   assign set_tf[`NIRQ_TF_CA_GUARD] = ca_guard_done;
   assign set_tf[`NIRQ_TF_RATE]     = target_mode & bitrate_found;

   // error and wake-up set terms
   assign set_err[`NIRQ_ERR_CRC]   = crc_err;
   assign set_err[`NIRQ_ERR_PAR]   = parity_err;
   assign set_err[`NIRQ_ERR_SOFT]  = soft_framing_err;
   assign set_err[`NIRQ_ERR_HARD]  = hard_framing_err;
   assign set_err[`NIRQ_ERR_WUT]   = wakeup_timeout & ctrl_r[`NIRQ_CTRL_WUT_EVERY];
   assign set_err[`NIRQ_ERR_AMP]   = over_ref(am_done, am_delta, wref_r[`NIRQ_WREF_AM_LSB +: MEAS_W]);
   assign set_err[`NIRQ_ERR_PHASE] = over_ref(pm_done, pm_delta, wref_r[`NIRQ_WREF_PM_LSB +: MEAS_W]);
   assign set_err[`NIRQ_ERR_CAP]   = over_ref(cm_done, cm_delta, wref_r[`NIRQ_WREF_CM_LSB +: MEAS_W]);

   assign main_nxt = flag_upd(main_event_flags_r, set_main, clr_main) &
                     ~`NIRQ_MAIN_UNUSED;
   assign tf_nxt   = flag_upd(timer_field_event_flags_r, set_tf, clr_tf);
   assign err_nxt  = flag_upd(error_wakeup_event_flags_r, set_err, clr_err);

   // request level from flags and masks, one bit mask per flag
   assign irq_nxt = |(main_nxt & ~mask_main_nxt) |
                    |(tf_nxt & ~mask_tf_nxt) |
                    |(err_nxt & ~mask_err_nxt);

   // write data phase, forwarded so a read right behind sees it
   always @* begin
      mask_main_nxt = mask_main_r;
      mask_tf_nxt   = mask_tf_r;
      mask_err_nxt  = mask_err_r;
      ctrl_nxt      = ctrl_r;
      wref_nxt      = wref_r;
      if (wr_pend_r) begin
         case (wr_addr_r)
            idx_addr(`NIRQ_IDX_MASK_MAIN): mask_main_nxt = hwdata[7:0] & ~`NIRQ_MAIN_UNUSED;
            idx_addr(`NIRQ_IDX_MASK_TF):   mask_tf_nxt   = hwdata[7:0];
            idx_addr(`NIRQ_IDX_MASK_ERR):  mask_err_nxt  = hwdata[7:0];
            idx_addr(`NIRQ_IDX_CTRL):      ctrl_nxt      = hwdata[1:0];
            idx_addr(`NIRQ_IDX_WREF):      wref_nxt      = hwdata[23:0];
            default: begin
               ctrl_nxt = ctrl_r;
            end
         endcase
      end
   end

   // read mux and clear-on-read strobes
   always @* begin
      rd_nxt   = 32'h00000000;
      clr_main = 1'b0;
      clr_tf   = 1'b0;
      clr_err  = 1'b0;
      if (rd_acc) begin
         case (a_addr)
            idx_addr(`NIRQ_IDX_MASK_MAIN): rd_nxt = word8(mask_main_nxt);
            idx_addr(`NIRQ_IDX_MASK_TF):   rd_nxt = word8(mask_tf_nxt);
            idx_addr(`NIRQ_IDX_MASK_ERR):  rd_nxt = word8(mask_err_nxt);
            idx_addr(`NIRQ_IDX_CTRL):      rd_nxt = {30'h0, ctrl_nxt};
            idx_addr(`NIRQ_IDX_WREF):      rd_nxt = {8'h00, wref_nxt};
            idx_addr(`NIRQ_IDX_MAIN): begin
               rd_nxt   = word8(main_event_flags_r);
               clr_main = 1'b1;
            end
            idx_addr(`NIRQ_IDX_TF): begin
               rd_nxt = word8(timer_field_event_flags_r);
               clr_tf = 1'b1;
            end
            idx_addr(`NIRQ_IDX_ERR): begin
               rd_nxt  = word8(error_wakeup_event_flags_r);
               clr_err = 1'b1;
            end
            default: begin
               rd_nxt = 32'h00000000;
            end
         endcase
      end
   end

   // event flags
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         main_event_flags_r         <= `NIRQ_RST_FLAGS;
         timer_field_event_flags_r  <= `NIRQ_RST_FLAGS;
         error_wakeup_event_flags_r <= `NIRQ_RST_FLAGS;
      end else begin
         main_event_flags_r         <= main_nxt;
         timer_field_event_flags_r  <= tf_nxt;
         error_wakeup_event_flags_r <= err_nxt;
      end
   end

   // masks, control and wake-up references
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mask_main_r <= `NIRQ_RST_MASK;
         mask_tf_r   <= `NIRQ_RST_MASK;
         mask_err_r  <= `NIRQ_RST_MASK;
         ctrl_r      <= `NIRQ_RST_CTRL;
         wref_r      <= `NIRQ_RST_WREF;
      end else begin
         mask_main_r <= mask_main_nxt;
         mask_tf_r   <= mask_tf_nxt;
         mask_err_r  <= mask_err_nxt;
         ctrl_r      <= ctrl_nxt;
         wref_r      <= wref_nxt;
      end
   end

   // write address phase kept for the data phase
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= acc & hwrite;
         if (acc) begin
            wr_addr_r <= a_addr;
         end
      end
   end

   // bus answer: zero wait states, always okay
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hrdata_r    <= 32'h00000000;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
         if (rd_acc) begin
            hrdata_r <= rd_nxt;
         end
      end
   end

   // request line
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // edge detector history
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         osc_stable_d_r <= 1'b0;
         field_d_r      <= 1'b0;
         wl_cond_d_r    <= 1'b0;
      end else begin
         osc_stable_d_r <= osc_stable;
         field_d_r      <= ext_field_on;
         wl_cond_d_r    <= wl_cond;
      end
   end

endmodule

// file: src/nirq_defs.vh
// constants for the event flag collector: register indexes, field bits,
// reset values and thresholds; byte address is four times the index
`ifndef NIRQ_DEFS_VH
`define NIRQ_DEFS_VH

// register indexes
`define NIRQ_IDX_MASK_MAIN   8'h16
`define NIRQ_IDX_MASK_TF     8'h17
`define NIRQ_IDX_MASK_ERR    8'h18
`define NIRQ_IDX_MAIN        8'h1A
`define NIRQ_IDX_TF          8'h1B
`define NIRQ_IDX_ERR         8'h1C
`define NIRQ_IDX_CTRL        8'h30
`define NIRQ_IDX_WREF        8'h31

// main event bits
`define NIRQ_MAIN_OSC        7
`define NIRQ_MAIN_WL         6
`define NIRQ_MAIN_RXS        5
`define NIRQ_MAIN_RXE        4
`define NIRQ_MAIN_TXE        3
`define NIRQ_MAIN_COL        2
`define NIRQ_MAIN_REST       1
`define NIRQ_MAIN_UNUSED     8'h01

// timer and field event bits
`define NIRQ_TF_CMD          7
`define NIRQ_TF_NRT          6
`define NIRQ_TF_GPT          5
`define NIRQ_TF_FON          4
`define NIRQ_TF_FOFF         3
`define NIRQ_TF_CA_COL       2
`define NIRQ_TF_CA_GUARD     1
`define NIRQ_TF_RATE         0

// error and wake-up event bits
`define NIRQ_ERR_CRC         7
`define NIRQ_ERR_PAR         6
`define NIRQ_ERR_SOFT        5
`define NIRQ_ERR_HARD        4
`define NIRQ_ERR_WUT         3
`define NIRQ_ERR_AMP         2
`define NIRQ_ERR_PHASE       1
`define NIRQ_ERR_CAP         0

// control register bits
`define NIRQ_CTRL_OSC_EN     0
`define NIRQ_CTRL_WUT_EVERY  1

// wake-up reference fields in the reference register
`define NIRQ_WREF_AM_LSB     0
`define NIRQ_WREF_PM_LSB     8
`define NIRQ_WREF_CM_LSB     16

// reset values
`define NIRQ_RST_MASK        8'h00
`define NIRQ_RST_FLAGS       8'h00
`define NIRQ_RST_CTRL        2'h0
`define NIRQ_RST_WREF        24'h000000

// fifo water levels in bytes
`define NIRQ_WL_RX_BYTES     300
`define NIRQ_WL_TX_BYTES     200

`endif

// file: tb/nirq_status_asserts.sv
// checker for the event flag collector: irq, osc enable and bus answer
// assumes one bus master; mask shadows follow the bus write data phase
`timescale 1ns/1ns
`include "nirq_defs.vh"

module nirq_status_asserts (
   // clock and reset
   input wire        ref_clk,
   input wire        reset,
   // bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   // events and outputs
   input wire        osc_en,
   input wire        rx_start,
   input wire        dcmd_done,
   input wire        crc_err,
   input wire        hard_framing_err,
   input wire        ext_field_on,
   input wire        irq
);
   localparam [31:0] A_MM = `NIRQ_IDX_MASK_MAIN * 4;
   localparam [31:0] A_MT = `NIRQ_IDX_MASK_TF * 4;
   localparam [31:0] A_ME = `NIRQ_IDX_MASK_ERR * 4;
   localparam [31:0] A_CT = `NIRQ_IDX_CTRL * 4;
   reg        wv_r;
   reg [31:0] wa_r;
   reg [7:0]  mm_r;
   reg [7:0]  mt_r;
   reg [7:0]  me_r;
   reg        am_r;
   wire       all_m = (&mm_r[7:1]) & (&mt_r) & (&me_r);
   // mask shadows, written at the data-phase edge
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wv_r <= 1'b0;
         wa_r <= 32'h0;
         mm_r <= 8'h00;
         mt_r <= 8'h00;
         me_r <= 8'h00;
         am_r <= 1'b0;
      end else begin
         wv_r <= hsel & htrans[1] & hready & hwrite;
         wa_r <= haddr;
         am_r <= all_m;
         if (wv_r && wa_r == A_MM) mm_r <= hwdata[7:0];
         if (wv_r && wa_r == A_MT) mt_r <= hwdata[7:0];
         if (wv_r && wa_r == A_ME) me_r <= hwdata[7:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_ctrl_wr;
      hsel && htrans[1] && hready && hwrite && haddr == A_CT ##1 hready;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
   a_osc_en_follow: assert property (s_ctrl_wr |=> osc_en == $past(hwdata[0]))
      else $error("osc enable does not follow control write");
   a_rxs_irq_up: assert property (rx_start && !mm_r[5] |-> ##[1:2] irq)
      else $error("rx start gave no irq");
   a_dcmd_irq_up: assert property (dcmd_done && !mt_r[7] |-> ##[1:2] irq)
      else $error("command done gave no irq");
   a_field_irq_up: assert property ($rose(ext_field_on) && !mt_r[4] |-> ##[1:2] irq)
      else $error("field rise gave no irq");
   a_crc_irq_up: assert property (crc_err && !me_r[7] |-> ##[1:2] irq)
      else $error("crc error gave no irq");
   a_hard_irq_up: assert property (hard_framing_err && !me_r[4] |-> ##[1:2] irq)
      else $error("hard framing gave no irq");
   a_masked_quiet: assert property (all_m && am_r |-> !irq) else $error("irq with all masked");
endmodule

bind nirq_status nirq_status_asserts i_nirq_status_asserts (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .osc_en(osc_en), .rx_start(rx_start), .dcmd_done(dcmd_done), .crc_err(crc_err),
   .hard_framing_err(hard_framing_err), .ext_field_on(ext_field_on), .irq(irq));

// file: tb/nirq_host.sv
// host model: single word transfers as bus master
// assumes hready is the slave's hreadyout
`timescale 1ns/1ns

module nirq_host (
   // clock
   input  wire        ref_clk,
   // bus answer
   input  wire        hready,
   input  wire [31:0] hrdata,
   // bus request
   output reg         hsel = 1'b0,
   output reg  [31:0] haddr = 32'h0,
   output reg  [1:0]  htrans = 2'h0,
   output reg         hwrite = 1'b0,
   output reg  [2:0]  hsize = 3'h2,
   output reg  [31:0] hwdata = 32'h0
);
   task xfer(input wr, input [31:0] a, input [31:0] wd, output [31:0] rd);
      begin
         @(posedge ref_clk);
         hsel <= 1'b1;
         haddr <= a;
         htrans <= 2'h2;
         hwrite <= wr;
         @(posedge ref_clk);
         while (hready !== 1'b1) @(posedge ref_clk);
         hsel <= 1'b0;
         htrans <= 2'h0;
         // read data phase: write data not held
         hwdata <= wr ? wd : ~hwdata;
         @(posedge ref_clk);
         while (hready !== 1'b1) @(posedge ref_clk);
         rd = hrdata;
      end
   endtask
endmodule

// file: tb/nirq_status_tb.sv
// testbench for the event flag collector
// assumes the host model drives the bus; events are one-cycle pulses
`timescale 1ns/1ns
`include "nirq_defs.vh"

module nirq_status_tb;
   localparam [31:0] A_MM = `NIRQ_IDX_MASK_MAIN * 4;
   localparam [31:0] A_MT = `NIRQ_IDX_MASK_TF * 4;
   localparam [31:0] A_ME = `NIRQ_IDX_MASK_ERR * 4;
   localparam [31:0] A_MN = `NIRQ_IDX_MAIN * 4;
   localparam [31:0] A_TF = `NIRQ_IDX_TF * 4;
   localparam [31:0] A_ER = `NIRQ_IDX_ERR * 4;
   localparam [31:0] A_CT = `NIRQ_IDX_CTRL * 4;
   localparam [31:0] A_WR = `NIRQ_IDX_WREF * 4;
   reg         ref_clk = 1'b0;
   reg         reset = 1'b1;
   reg  [18:0] ev = 19'h0;
   reg         osc_stable = 1'b0;
   reg         rx_active = 1'b0;
   reg         tx_active = 1'b0;
   reg         ext_field_on = 1'b0;
   reg         target_mode = 1'b0;
   reg  [9:0]  fifo_count = 10'h0;
   reg  [7:0]  dl = 8'h00;
   wire        hsel, hwrite, hready, hresp, osc_en, irq;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0]  htrans;
   wire [2:0]  hsize;
   integer     mismatches = 0;
   integer     checked = 0;

   nirq_host i_nirq_host (.ref_clk(ref_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   nirq_status i_nirq_status (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .osc_en(osc_en), .osc_stable(osc_stable), .rx_active(rx_active), .tx_active(tx_active),
      .fifo_count(fifo_count), .rx_start(ev[0]), .rx_end(ev[1]), .tx_end(ev[2]), .bit_collision(ev[3]),
      .electromagnetic_disturbance(ev[4]), .dcmd_done(ev[5]), .nrt_expire(ev[6]), .gpt_expire(ev[7]),
      .ca_collision(ev[8]), .ca_guard_done(ev[9]), .bitrate_found(ev[10]), .ext_field_on(ext_field_on),
      .target_mode(target_mode), .crc_err(ev[11]), .parity_err(ev[12]), .soft_framing_err(ev[13]),
      .hard_framing_err(ev[14]), .wakeup_timeout(ev[15]), .am_done(ev[16]), .am_delta(dl), .pm_done(ev[17]),
      .pm_delta(dl), .cm_done(ev[18]), .cm_delta(dl), .irq(irq));

   initial forever #20 ref_clk = ~ref_clk;

   task chk_reg(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk_bit(input got, input exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t signal %b expected %b", $time, got, exp);
         end
      end
   endtask
   task rd(input [31:0] a, input [31:0] e);
      reg [31:0] d;
      begin
         i_nirq_host.xfer(1'b0, a, 32'h0, d);
         chk_reg(d, e);
      end
   endtask
   task wr(input [31:0] a, input [31:0] v);
      reg [31:0] d;
      begin
         i_nirq_host.xfer(1'b1, a, v, d);
      end
   endtask
   task pulse(input [18:0] m);
      begin
         @(posedge ref_clk);
         ev <= m;
         @(posedge ref_clk);
         ev <= 19'h0;
      end
   endtask
   task irq_is(input e);
      begin
         repeat (2) @(posedge ref_clk);
         #1 chk_bit(irq, e);
      end
   endtask

   task t_reset;
      begin
         chk_bit(irq, 1'b0);
         rd(A_MM, 32'h0);
         rd(A_MT, 32'h0);
         rd(A_ME, 32'h0);
         rd(A_CT, 32'h0);
         rd(32'h100, 32'h0);
         wr(A_MN, 32'hFF);
         rd(A_MN, 32'h0);
         $display("test reset done");
      end
   endtask
   task t_main;
      begin
         pulse(19'h1F);
         irq_is(1'b1);
         rd(A_MN, 32'h3E);
         rd(A_MN, 32'h0);
         irq_is(1'b0);
         @(posedge ref_clk);
         osc_stable <= 1'b1;
         irq_is(1'b0);
         @(posedge ref_clk);
         osc_stable <= 1'b0;
         wr(A_CT, 32'h1);
         #1 chk_bit(osc_en, 1'b1);
         @(posedge ref_clk);
         osc_stable <= 1'b1;
         irq_is(1'b1);
         rd(A_MN, 32'h80);
         $display("test main done");
      end
   endtask
   task t_fifo;
      begin
         @(posedge ref_clk);
         rx_active <= 1'b1;
         fifo_count <= 10'd300;
         irq_is(1'b0);
         @(posedge ref_clk);
         fifo_count <= 10'd301;
         irq_is(1'b1);
         rd(A_MN, 32'h40);
         @(posedge ref_clk);
         rx_active <= 1'b0;
         tx_active <= 1'b1;
         fifo_count <= 10'd200;
         irq_is(1'b0);
         @(posedge ref_clk);
         fifo_count <= 10'd199;
         irq_is(1'b1);
         rd(A_MN, 32'h40);
         tx_active <= 1'b0;
         $display("test fifo done");
      end
   endtask
   task t_tf;
      begin
         pulse(19'h3E0);
         ext_field_on <= 1'b1;
         pulse(19'h400);
         rd(A_TF, 32'hF6);
         target_mode <= 1'b1;
         ext_field_on <= 1'b0;
         pulse(19'h400);
         irq_is(1'b1);
         rd(A_TF, 32'h09);
         rd(A_TF, 32'h0);
         target_mode <= 1'b0;
         $display("test timer field done");
      end
   endtask
   task t_err;
      begin
         wr(A_WR, 32'h070605);
         rd(A_WR, 32'h070605);
         pulse(19'h7800);
         pulse(19'h8000);
         rd(A_ER, 32'hF0);
         wr(A_CT, 32'h3);
         rd(A_CT, 32'h3);
         pulse(19'h8000);
         rd(A_ER, 32'h08);
         dl <= 8'h06;
         pulse(19'h70000);
         rd(A_ER, 32'h04);
         dl <= 8'h08;
         pulse(19'h70000);
         rd(A_ER, 32'h07);
         rd(A_ER, 32'h0);
         $display("test error done");
      end
   endtask
   task t_mask;
      begin
         wr(A_MM, 32'hFE);
         pulse(19'h1);
         irq_is(1'b0);
         rd(A_MN, 32'h20);
         wr(A_ME, 32'h20);
         pulse(19'h2000);
         irq_is(1'b0);
         pulse(19'h4000);
         irq_is(1'b1);
         rd(A_ER, 32'h30);
         wr(A_MT, 32'hFF);
         wr(A_ME, 32'hFF);
         rd(A_MM, 32'hFE);
         pulse(19'h7FBFF);
         irq_is(1'b0);
         rd(A_MN, 32'h3E);
         rd(A_TF, 32'hE6);
         rd(A_ER, 32'hFF);
         $display("test mask done");
      end
   endtask

   task print_verdict;
      begin
         $display("checked %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset;
      t_main;
      t_fifo;
      t_tf;
      t_err;
      t_mask;
      print_verdict;
   end
   initial begin
      repeat (4000) @(posedge ref_clk);
      mismatches = mismatches + 1;
      print_verdict;
   end
endmodule
